// File: src/sto_monitor.v
`timescale 1ns/1ps
`include "sto_map.vh"
// Contract
// - Either safety supply line interrupted, or both, means safe torque off active.
// - Contacts closed: ready 1, no error; enable 1 gives acknowledge and pwm.
// - Torque off with enable 0: ready stays 1, pulses inhibited, no error.
// - Torque off with enable 1: ready 0, pulses inhibited, error 2320.
// - Torque off while moving: stop gating, drive coasts, report error 2320.
// - Torque off cuts gate control at once and blocks unexpected restart.
// - Drives sharing one safety signal enter and leave torque off together.
// - A local drive fault never changes the shared torque off state.
// - Standard variant closes holding brake whenever torque off becomes active.
// - Missing safety supply always means torque off is effective.
// - Later revision: torque off does not touch brake; brake follows own supply.
// - Torque off enforced within 1 ms standard, 5 ms later revision.
// - Error reaction begins within 20 ms after torque off triggers.
// - Diagnostic message visible within 200 ms of the event.
// - Class A: immediate shutdown, output stage blocked, drive coasts.
// - Class B: brake to standstill first, then shut down power stage.
// - Class W: warning, 4 second timer, shutdown when timer expires.
// - Class A for overcurrent, phase short, watchdog, supply fault, resistor short.
// - Class W for overtemperature and squared current overload.
// - Class A for bus voltage, deviation, velocity, position, transistor, encoder, deceleration.
// - Missing fieldbus participant triggers class B.
module sto_monitor #(
  parameter REV4         = 0,
  parameter WARN_CYCLES  = `STO_WARN_MS * `STO_CLK_MHZ * 1000,
  parameter DIAG_CYCLES  = `STO_DIAG_US * `STO_CLK_MHZ,
  parameter SWREACT_CYC  = `STO_SWREACT_US * `STO_CLK_MHZ
) (
  input  wire                   clock,
  input  wire                   reset,
  input  wire                   safetySupplyPos,
  input  wire                   safetySupplyRet,
  input  wire                   brakeSupplyOk,
  input  wire                   controllerEnableSignal,
  input  wire                   motorMoving,
  input  wire                   brakeRequest,
  input  wire [`STO_HW_A_W-1:0] hwFaultA,
  input  wire [`STO_SW_A_W-1:0] swFaultA,
  input  wire [`STO_SW_W_W-1:0] swFaultW,
  input  wire                   participantMissing,
  input  wire                   brakeStopDone,
  input  wire                   faultClear,
  output reg                    stoActive_ff,
  output reg                    driveReady_ff,
  output reg                    enableAcknowledge_ff,
  output reg                    gateEnable_ff,
  output reg                    pwmActive_ff,
  output reg                    brakeRelease_ff,
  output reg                    decelCommand_ff,
  output reg                    warning_ff,
  output reg                    errorValid_ff,
  output reg  [15:0]            errorCode_ff,
  output reg  [1:0]             faultClass_ff,
  output reg                    errorReaction_ff,
  output reg                    diagVisible_ff
);

  localparam ST_RUN   = 4'h1;
  localparam ST_WARN  = 4'h2;
  localparam ST_BRAKE = 4'h4;
  localparam ST_OFF   = 4'h8;

  function [31:0] satInc;
    input [31:0] v;
    input [31:0] lim;
    begin
      satInc = (v >= lim) ? lim : v + 32'h00000001;
    end
  endfunction

  // Gates may run only with the supply present, no shutdown and the restart lock open.
  function gateAllowed;
    input sto;
    input off;
    input lock;
    begin
      gateAllowed = ~sto & ~off & ~lock;
    end
  endfunction

  // Class priority is A over B over W.
  function [1:0] classOf;
    input a;
    input b;
    input w;
    begin
      if (a) begin
        classOf = `STO_CLASS_A;
      end else if (b) begin
        classOf = `STO_CLASS_B;
      end else if (w) begin
        classOf = `STO_CLASS_W;
      end else begin
        classOf = `STO_CLASS_NONE;
      end
    end
  endfunction

  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [31:0] warnCnt_ff;
  reg  [31:0] reactCnt_ff;
  reg  [31:0] diagCnt_ff;
  reg         restartLock_ff;
  reg         sto2320_ff;

  wire stoNow   = ~safetySupplyPos | ~safetySupplyRet;
  wire faultA   = (|hwFaultA) | (|swFaultA);
  wire faultW   = |swFaultW;
  wire faultB   = participantMissing;
  wire stoErr   = stoNow & (controllerEnableSignal | motorMoving);
  wire shutdown = (state_ff == ST_OFF);

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (faultA) begin
          nxt_state = ST_OFF;
        end else if (faultB) begin
          nxt_state = ST_BRAKE;
        end else if (faultW) begin
          nxt_state = ST_WARN;
        end
      end
      ST_WARN: begin
        if (faultA || warnCnt_ff >= WARN_CYCLES - 1) begin
          nxt_state = ST_OFF;
        end else if (faultB) begin
          nxt_state = ST_BRAKE;
        end
      end
      ST_BRAKE: begin
        if (faultA || brakeStopDone || stoNow) begin
          nxt_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (faultClear && !faultA && !faultB && !faultW) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The warning timer runs only while the warning state is held.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      warnCnt_ff <= 32'h00000000;
    end else if (state_ff == ST_WARN) begin
      warnCnt_ff <= satInc(warnCnt_ff, WARN_CYCLES);
    end else begin
      warnCnt_ff <= 32'h00000000;
    end
  end

  // The reaction and diagnostic counters run while error 2320 stands.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reactCnt_ff <= 32'h00000000;
    end else if (sto2320_ff) begin
      reactCnt_ff <= satInc(reactCnt_ff, SWREACT_CYC);
    end else begin
      reactCnt_ff <= 32'h00000000;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      diagCnt_ff <= 32'h00000000;
    end else if (sto2320_ff) begin
      diagCnt_ff <= satInc(diagCnt_ff, DIAG_CYCLES);
    end else begin
      diagCnt_ff <= 32'h00000000;
    end
  end

  // Torque off follows the raw supply through one register stage, far inside the 1 ms bound.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stoActive_ff <= 1'b1;
    end else begin
      stoActive_ff <= stoNow;
    end
  end

  // Restart needs the enable to drop after torque off or shutdown clears.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      restartLock_ff <= 1'b1;
    end else if (stoNow || shutdown) begin
      restartLock_ff <= 1'b1;
    end else if (!controllerEnableSignal) begin
      restartLock_ff <= 1'b0;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      gateEnable_ff <= 1'b0;
    end else begin
      gateEnable_ff <= gateAllowed(stoNow, shutdown, restartLock_ff);
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pwmActive_ff <= 1'b0;
    end else begin
      pwmActive_ff <= gateAllowed(stoNow, shutdown, restartLock_ff) & controllerEnableSignal;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      enableAcknowledge_ff <= 1'b0;
    end else begin
      enableAcknowledge_ff <= gateAllowed(stoNow, shutdown, restartLock_ff) & controllerEnableSignal;
    end
  end

  // Torque off alone keeps the drive ready; only a pending enable or a shutdown clears it.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      driveReady_ff <= 1'b1;
    end else begin
      driveReady_ff <= ~(stoNow & controllerEnableSignal) & ~shutdown;
    end
  end

  // Once raised, error 2320 stays while torque off persists, even if the enable drops.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sto2320_ff <= 1'b0;
    end else begin
      sto2320_ff <= stoErr | (sto2320_ff & stoNow);
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      brakeRelease_ff <= 1'b0;
    end else if (REV4 != 0) begin
      brakeRelease_ff <= brakeSupplyOk & brakeRequest & ~shutdown;
    end else begin
      brakeRelease_ff <= brakeSupplyOk & brakeRequest & ~shutdown & ~stoNow;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      decelCommand_ff <= 1'b0;
    end else begin
      decelCommand_ff <= (state_ff == ST_BRAKE);
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      warning_ff <= 1'b0;
    end else begin
      warning_ff <= (state_ff == ST_WARN);
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      errorValid_ff <= 1'b0;
    end else begin
      errorValid_ff <= sto2320_ff | shutdown;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      errorCode_ff <= 16'h0000;
    end else if (sto2320_ff) begin
      errorCode_ff <= `STO_ERR_EF_OFF;
    end else begin
      errorCode_ff <= 16'h0000;
    end
  end

  // The class is kept through shutdown and cleared only once the drive runs again.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      faultClass_ff <= `STO_CLASS_NONE;
    end else if (faultA || faultB || faultW) begin
      faultClass_ff <= classOf(faultA, faultB, faultW);
    end else if (state_ff == ST_RUN) begin
      faultClass_ff <= `STO_CLASS_NONE;
    end
  end

  // Error reaction starts on the first counted cycle, well inside the 20 ms bound.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      errorReaction_ff <= 1'b0;
    end else begin
      errorReaction_ff <= sto2320_ff & (reactCnt_ff != 32'h00000000);
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      diagVisible_ff <= 1'b0;
    end else begin
      diagVisible_ff <= sto2320_ff & (diagCnt_ff != 32'h00000000);
    end
  end

endmodule

// File: src/sto_map.vh
`ifndef STO_MAP_VH
`define STO_MAP_VH
`define STO_CLK_MHZ        250
`define STO_ERR_EF_OFF     16'h0910
`define STO_REACT_STD_US   1000
`define STO_REACT_REV4_US  5000
`define STO_SWREACT_US     20000
`define STO_DIAG_US        200000
`define STO_WARN_MS        4000
`define STO_CLASS_NONE     2'h0
`define STO_CLASS_A        2'h1
`define STO_CLASS_B        2'h2
`define STO_CLASS_W        2'h3
`define STO_HW_A_W         5
`define STO_SW_A_W         8
`define STO_SW_W_W         2
`endif

// File: tb/sto_monitor_properties.sv
`timescale 1ns/1ps
module sto_monitor_properties #(parameter REV4 = 0) (
  input wire logic        clock, reset, safetySupplyPos, safetySupplyRet, brakeSupplyOk,
  input wire logic        controllerEnableSignal, motorMoving, participantMissing,
  input wire logic [4:0]  hwFaultA,
  input wire logic [7:0]  swFaultA,
  input wire logic [1:0]  swFaultW,
  input wire logic        stoActive_ff, driveReady_ff, gateEnable_ff, pwmActive_ff, brakeRelease_ff,
  input wire logic        errorValid_ff, errorReaction_ff, diagVisible_ff,
  input wire logic [15:0] errorCode_ff,
  input wire logic [1:0]  faultClass_ff
);
  wire stoNow = !safetySupplyPos || !safetySupplyRet;
  wire faultA = |hwFaultA || |swFaultA;
  wire calm = !faultA && !(|swFaultW) && !participantMissing && !motorMoving && !controllerEnableSignal;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_sto_cut: assert property (stoNow |=> stoActive_ff && !gateEnable_ff && !pwmActive_ff)
    else $error("gates not cut in torque off");
  a_ready_drop: assert property (stoNow && controllerEnableSignal |=> !driveReady_ff)
    else $error("ready kept with enable in torque off");
  a_enable_error: assert property (stoNow && controllerEnableSignal ##1 stoNow[*2] |=>
    errorValid_ff && errorCode_ff == 16'h0910) else $error("enable path error missing");
  a_moving_error: assert property (stoNow && motorMoving ##1 stoNow[*2] |=> errorCode_ff == 16'h0910)
    else $error("moving stop error missing");
  a_ready_keep: assert property ((stoNow && calm && driveReady_ff && !errorValid_ff)[*4] |=>
    driveReady_ff && !errorValid_ff) else $error("ready lost with enable low");
  a_brake_close: assert property (REV4 == 0 && stoNow |=> !brakeRelease_ff)
    else $error("brake open in torque off");
  a_brake_supply: assert property (!brakeSupplyOk |=> !brakeRelease_ff)
    else $error("brake open without its supply");
  a_class_a: assert property (faultA |-> ##[1:2] (faultClass_ff == 2'h1 && !gateEnable_ff))
    else $error("class A shutdown missing");
  a_diag_show: assert property (stoNow && (controllerEnableSignal || motorMoving) ##1 stoNow[*2] |=>
    errorReaction_ff && diagVisible_ff)
    else $error("reaction or diagnostic late");
endmodule
bind sto_monitor sto_monitor_properties #(.REV4(REV4)) u_prop (.*);

// File: tb/sto_partner.sv
`timescale 1ns/1ps
// Two-channel safety switch; an opened channel takes its line low.
module sto_partner (
  input wire logic openPos,
  input wire logic openRet,
  output logic     safetySupplyPos,
  output logic     safetySupplyRet
);
  assign safetySupplyPos = !openPos;
  assign safetySupplyRet = !openRet;
endmodule

// File: tb/sto_monitor_tb_top.sv
`timescale 1ns/1ps
module sto_monitor_tb_top;
  logic clock = 0, reset = 1, openPos = 0, openRet = 0, en = 0, mv = 0, bsOk = 1, pMiss = 0, bDone = 0, fClr = 0;
  logic [4:0] hwA = 0;
  logic [7:0] swA = 0;
  logic [1:0] swW = 0, fC;
  logic sPos, sRet, sto, rdy, ack, gate, pwm, brk, dec, warn, eV, eR, dV;
  logic [15:0] eC;
  int error_cnt = 0, num_checks = 0, i;
  integer seed = 32'h4d0b519e;
  always #2 clock = ~clock;
  sto_partner u_sw (.openPos(openPos), .openRet(openRet), .safetySupplyPos(sPos), .safetySupplyRet(sRet));
  sto_monitor #(.WARN_CYCLES(20)) u_dut (.clock(clock), .reset(reset), .safetySupplyPos(sPos),
    .safetySupplyRet(sRet), .brakeSupplyOk(bsOk), .controllerEnableSignal(en), .motorMoving(mv),
    .brakeRequest(1'b1), .hwFaultA(hwA), .swFaultA(swA), .swFaultW(swW), .participantMissing(pMiss),
    .brakeStopDone(bDone), .faultClear(fClr), .stoActive_ff(sto), .driveReady_ff(rdy),
    .enableAcknowledge_ff(ack), .gateEnable_ff(gate), .pwmActive_ff(pwm), .brakeRelease_ff(brk),
    .decelCommand_ff(dec), .warning_ff(warn), .errorValid_ff(eV), .errorCode_ff(eC), .faultClass_ff(fC),
    .errorReaction_ff(eR), .diagVisible_ff(dV));
  function logic [15:0] code(input logic e);
    return e ? 16'h0910 : 16'h0000;
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Clears every fault source and pulses the clear so the next case starts from a running drive.
  task recover;
    {openPos, openRet, en, mv, pMiss, bDone, fClr, hwA, swA, swW} = {7'h01, 15'h0000};
    cyc(3);
    fClr = 0;
    cyc(1);
    en = 1;
    cyc(3);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    finish_test;
  end
  initial begin
    cyc(4);
    reset = 0;
    cyc(2);
    chk({rdy, eV}, 2'h2);
    en = 1;
    cyc(3);
    chk({ack, pwm, gate, brk}, 4'hF);
    bsOk = 0;
    cyc(2);
    chk(brk, 0);
    bsOk = 1;
    $display("run test done");
    for (i = 0; i < 6; i++) begin
      en = i > 2;
      mv = i == 2;
      cyc(2);
      {openPos, openRet} = 2'(i % 3 + 1);
      cyc(1);
      chk({sto, gate, pwm, brk}, 4'h8);
      cyc(4);
      chk(eC, code(en | mv));
      chk({eR, dV}, (en | mv) ? 2'h3 : 2'h0);
      if (!mv) chk(rdy, !en);
      {openPos, openRet} = 2'h0;
      cyc(3);
      if (en) chk(gate, 0);
      recover;
    end
    $display("torque off test done");
    for (i = 0; i < 12; i++) begin
      {pMiss, swW} = 3'($random(seed));
      if (i < 5) hwA[i] = 1;
      else swA[i-5] = 1;
      cyc(3);
      chk({fC, gate, rdy, sto}, 5'h08);
      recover;
    end
    swW = 2'($random(seed)) | 2'h1;
    cyc(3);
    chk({warn, fC, gate}, 4'hF);
    cyc(25);
    chk({gate, rdy}, 2'h0);
    recover;
    pMiss = 1;
    cyc(3);
    chk({dec, gate}, 2'h3);
    bDone = 1;
    cyc(3);
    chk({dec, gate, rdy}, 3'h0);
    $display("fault class test done");
    finish_test;
  end
endmodule
